//--- hdl/audio_sample_format_converter.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - four formats: signed 16, unsigned 8, mu-law 8, A-law 8
// - signed 16 is two's complement, 8000h lowest, 7FFFh highest
// - linear formats map codes to amplitude in equal steps
// - unsigned 8 codes lowest as 00h, highest as FFh, no sign
// - unsigned 8 output is the upper byte, low byte dropped unrounded
// - companded words are 8 bits, finer steps at small amplitudes
// - mu-law follows the mu equals 255 logarithmic law
// - A-law follows the international telephony A-law characteristic
module audio_sample_format_converter (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire fmt_conv_pkg::fmt_t fmt_in,
  input wire fmt_conv_pkg::sample_t enc_in,
  input wire fmt_conv_pkg::sample_t dec_in,
  output var fmt_conv_pkg::sample_t enc_out,
  output var fmt_conv_pkg::sample_t dec_out
);
  import fmt_conv_pkg::*;

  // mu-law encoder intermediates
  logic mu_e_sgn;
  logic [13:0] mu_e_mag;
  logic [14:0] mu_e_sum;
  logic [12:0] mu_e_lim;
  logic [2:0] mu_e_seg;
  logic [3:0] mu_e_mant;
  logic [7:0] mu_e_code;

  // mu-law decoder intermediates
  logic [7:0] mu_d_raw;
  logic [14:0] mu_d_step;
  logic [13:0] mu_d_mag;
  logic [15:0] mu_d_word;

  // A-law encoder intermediates
  logic a_e_sgn;
  logic [11:0] a_e_mag;
  logic [2:0] a_e_seg;
  logic [3:0] a_e_mant;
  logic [7:0] a_e_code;

  // A-law decoder intermediates
  logic [7:0] a_d_raw;
  logic [12:0] a_d_step;
  logic [15:0] a_d_word;

  // unsigned 8-bit paths
  logic [7:0] ul_e_code;
  logic [15:0] ul_d_word;

  // selected words ahead of the output registers
  logic [15:0] enc_word;
  logic [15:0] dec_word;

  // mu-law sign and 14-bit magnitude; one's complement keeps -1 on the zero code
  always_comb begin
    mu_e_sgn = enc_in.data[SIGN_POS];
    if (mu_e_sgn) begin
      mu_e_mag = ~enc_in.data[15:2];
    end else begin
      mu_e_mag = enc_in.data[15:2];
    end
  end

  // add the bias so each segment starts on a power of two
  always_comb begin
    mu_e_sum = {1'b0, mu_e_mag} + {1'b0, MU_BIAS};
  end

  // clip to the top of the last segment
  always_comb begin
    if (mu_e_sum > 15'h1FFF) begin
      mu_e_lim = 13'h1FFF;
    end else begin
      mu_e_lim = mu_e_sum[12:0];
    end
  end

  // segment is the leading one at bit 6 or above; below that it is segment 0
  always_comb begin
    mu_e_seg = 3'h0;
    for (int i = 6; i <= 12; i++) begin
      if (mu_e_lim[i]) begin
        mu_e_seg = 3'(i - 5);
      end
    end
  end

  // mantissa below the leading one; a 4-bit shift count lets segment 7 shift by 8
  always_comb begin
    mu_e_mant = 4'(mu_e_lim >> ({1'b0, mu_e_seg} + 4'h1));
  end

  // positive codes carry a set top bit once the whole word is inverted
  always_comb begin
    mu_e_code = {mu_e_sgn, mu_e_seg, mu_e_mant} ^ MU_INV;
  end

  // mu-law expand: rebuild the biased step, then take the bias back off
  always_comb begin
    mu_d_raw = dec_in.data[7:0] ^ MU_INV;
    mu_d_step = 15'(({11'h000, mu_d_raw[3:0]} << 1) + 15'h0021) << mu_d_raw[6:4];
    mu_d_mag = 14'(mu_d_step - {1'b0, MU_BIAS});
  end

  // inverted top bit set means a negative sample
  always_comb begin
    if (mu_d_raw[7]) begin
      mu_d_word = 16'(-{2'b00, mu_d_mag, 2'b00});
    end else begin
      mu_d_word = {mu_d_mag, 2'b00};
    end
  end

  // A-law sign and 12-bit magnitude of the 13-bit scaled sample
  always_comb begin
    a_e_sgn = enc_in.data[SIGN_POS];
    if (a_e_sgn) begin
      a_e_mag = ~enc_in.data[14:3];
    end else begin
      a_e_mag = enc_in.data[14:3];
    end
  end

  // segment is the leading one at bit 5 or above; segments 0 and 1 share a step
  always_comb begin
    a_e_seg = 3'h0;
    for (int i = 5; i <= 11; i++) begin
      if (a_e_mag[i]) begin
        a_e_seg = 3'(i - 4);
      end
    end
  end

  // mantissa below the leading one
  always_comb begin
    if (a_e_seg == 3'h0) begin
      a_e_mant = a_e_mag[4:1];
    end else begin
      a_e_mant = 4'(a_e_mag >> a_e_seg);
    end
  end

  // positive codes carry a set top bit; even bits are inverted on the line
  always_comb begin
    a_e_code = {~a_e_sgn, a_e_seg, a_e_mant} ^ A_INV;
  end

  // A-law expand to the midpoint of the coded step
  always_comb begin
    a_d_raw = dec_in.data[7:0] ^ A_INV;
    if (a_d_raw[6:4] == 3'h0) begin
      a_d_step = {8'h00, a_d_raw[3:0], 1'b1};
    end else begin
      a_d_step = 13'({8'h01, a_d_raw[3:0], 1'b1} << (a_d_raw[6:4] - 3'h1));
    end
  end

  // top bit set after the even-bit flip means a positive sample
  always_comb begin
    if (a_d_raw[7]) begin
      a_d_word = {a_d_step, 3'b000};
    end else begin
      a_d_word = 16'(-{a_d_step, 3'b000});
    end
  end

  // unsigned 8-bit encode: upper byte kept unrounded, sign bit flipped
  always_comb begin
    ul_e_code = {~enc_in.data[SIGN_POS], enc_in.data[14:BYTE_POS]};
  end

  // unsigned 8-bit decode: flip the top bit back and append a zero low byte
  always_comb begin
    ul_d_word = {~dec_in.data[7], dec_in.data[6:0], ZERO_BYTE};
  end

  // encode: internal sample to serial word format
  always_comb begin
    case (fmt_in)
      FMT_LIN16: enc_word = enc_in.data;
      FMT_ULIN8: enc_word = {ZERO_BYTE, ul_e_code};
      FMT_MULAW: enc_word = {ZERO_BYTE, mu_e_code};
      FMT_ALAW: enc_word = {ZERO_BYTE, a_e_code};
      default: enc_word = enc_in.data;
    endcase
  end

  // decode: serial word to internal sample
  always_comb begin
    case (fmt_in)
      FMT_LIN16: dec_word = dec_in.data;
      FMT_ULIN8: dec_word = ul_d_word;
      FMT_MULAW: dec_word = mu_d_word;
      FMT_ALAW: dec_word = a_d_word;
      default: dec_word = dec_in.data;
    endcase
  end

  // encoder output register
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      enc_out <= '{valid: 1'b0, data: RST_WORD};
    end else begin
      enc_out <= '{valid: enc_in.valid, data: enc_word};
    end
  end

  // decoder output register
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      dec_out <= '{valid: 1'b0, data: RST_WORD};
    end else begin
      dec_out <= '{valid: dec_in.valid, data: dec_word};
    end
  end

endmodule
`default_nettype wire

//--- hdl/fmt_conv_pkg.sv
`default_nettype none
package fmt_conv_pkg;

  // sample word formats on the serial side
  typedef enum logic [1:0] {
    FMT_LIN16,
    FMT_ULIN8,
    FMT_MULAW,
    FMT_ALAW
  } fmt_t;

  // one sample word with its valid strobe
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sample_t;

  localparam logic [15:0] LIN_MIN = 16'h8000;
  localparam logic [15:0] LIN_MAX = 16'h7FFF;
  localparam int SIGN_POS = 15;
  localparam int BYTE_POS = 8;
  localparam logic [7:0] ULIN_MIN = 8'h00;
  localparam logic [7:0] ULIN_MAX = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [13:0] MU_BIAS = 14'h0021;
  localparam logic [7:0] MU_INV = 8'hFF;
  localparam logic [7:0] A_INV = 8'h55;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int PIPE_CYCLES = 1;

endpackage
`default_nettype wire

//--- testbench/fmt_conv_props.sv
`timescale 1ns/1ps
`default_nettype none
module fmt_conv_props (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire fmt_conv_pkg::fmt_t fmt_in,
  input wire fmt_conv_pkg::sample_t enc_in,
  input wire fmt_conv_pkg::sample_t dec_in,
  input wire fmt_conv_pkg::sample_t enc_out,
  input wire fmt_conv_pkg::sample_t dec_out
);
  import fmt_conv_pkg::*;
  logic live_r;
  // high once the previous edge was out of reset
  always_ff @(posedge clk_in) live_r <= nrst_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_rst; disable iff (1'b0) !nrst_in |=> enc_out == '0 && dec_out == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_val; live_r |-> enc_out.valid == $past(enc_in.valid) &&
    dec_out.valid == $past(dec_in.valid); endproperty
  a_val: assert property (p_val) else $error("valid lost");
  property p_l16; live_r && $past(fmt_in) == FMT_LIN16 |-> dec_out.data == $past(dec_in.data);
  endproperty
  a_l16: assert property (p_l16) else $error("linear word altered");
  property p_u8e; live_r && $past(fmt_in) == FMT_ULIN8 |->
    enc_out.data == {ZERO_BYTE, ~$past(enc_in.data[15]), $past(enc_in.data[14:8])}; endproperty
  a_u8e: assert property (p_u8e) else $error("unsigned encode wrong");
  property p_u8d; live_r && $past(fmt_in) == FMT_ULIN8 |->
    dec_out.data == {~$past(dec_in.data[7]), $past(dec_in.data[6:0]), ZERO_BYTE}; endproperty
  a_u8d: assert property (p_u8d) else $error("unsigned decode wrong");
  property p_cmp; live_r && $past(fmt_in[1]) |-> enc_out.data[15:8] == ZERO_BYTE; endproperty
  a_cmp: assert property (p_cmp) else $error("companded word too wide");
  property p_mu0; live_r && $past(fmt_in) == FMT_MULAW && $past(dec_in.data[7:0]) == 8'hFF
    |-> dec_out.data == RST_WORD; endproperty
  a_mu0: assert property (p_mu0) else $error("mu zero code wrong");
  property p_asg; live_r && $past(fmt_in) == FMT_ALAW && $past(dec_in.data[7]) |->
    !dec_out.data[15] && dec_out.data != RST_WORD; endproperty
  a_asg: assert property (p_asg) else $error("a-law sign wrong");
endmodule
bind audio_sample_format_converter fmt_conv_props props_u (.clk_in, .nrst_in, .fmt_in,
  .enc_in, .dec_in, .enc_out, .dec_out);
`default_nettype wire

//--- testbench/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  output var fmt_conv_pkg::sample_t word_out
);
  import fmt_conv_pkg::*;
  // idle until the first word is handed over
  initial word_out = '0;
  task automatic send(input logic [15:0] w);
    word_out = {1'b1, w};
  endtask
endmodule
`default_nettype wire

//--- testbench/audio_sample_format_converter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module audio_sample_format_converter_tb;
  import fmt_conv_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  fmt_t fmt_in = FMT_LIN16;
  sample_t enc_in = '0;
  sample_t dec_in, enc_out, dec_out;
  int error_cnt = 0;
  int checks = 0;
  // 10 MHz clock
  always #50 clk_in = ~clk_in;
  serial_host_model host_u (.word_out(dec_in));
  audio_sample_format_converter dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .fmt_in(fmt_in),
    .enc_in(enc_in), .dec_in(dec_in), .enc_out(enc_out), .dec_out(dec_out));
  task automatic check(input string n, input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d of %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one word each way, judged one edge later
  task automatic conv(input fmt_t f, input logic [15:0] e, d, xe, xd);
    @(negedge clk_in);
    fmt_in = f;
    enc_in = {1'b1, e};
    host_u.send(d);
    @(negedge clk_in);
    check("enc_out", enc_out, {1'b1, xe});
    check("dec_out", dec_out, {1'b1, xd});
  endtask
  task automatic t_reset;
    @(negedge clk_in);
    nrst_in = 1'b0;
    repeat (6) @(negedge clk_in);
    check("enc_out", enc_out, '0);
    check("dec_out", dec_out, '0);
    nrst_in = 1'b1;
  endtask
  task automatic t_lin;
    conv(FMT_LIN16, 16'h8000, 16'h7FFF, 16'h8000, 16'h7FFF);
    conv(FMT_ULIN8, 16'h8000, 16'h00FF, 16'h0000, 16'h7F00);
    conv(FMT_ULIN8, 16'h01FF, 16'hAA80, 16'h0081, 16'h0000);
  endtask
  task automatic t_comp;
    conv(FMT_MULAW, 16'h0000, 16'h00FF, 16'h00FF, 16'h0000);
    conv(FMT_MULAW, 16'hFFFF, 16'h0000, 16'h007F, 16'h8284);
    conv(FMT_ALAW, 16'hFFFF, 16'hFF55, 16'h0055, 16'hFFF8);
    conv(FMT_MULAW, 16'h4000, 16'h008F, 16'h008F, 16'h417C);
    conv(FMT_ALAW, 16'h4000, 16'h00A5, 16'h00A5, 16'h4200);
  endtask
  // watchdog well past the expected run
  initial begin
    #20000;
    error_cnt++;
    complete_run;
  end
  initial begin
    t_reset;
    t_lin;
    t_reset;
    t_comp;
    complete_run;
  end
endmodule
`default_nettype wire
